// ===== rtl/rdpt_cfg.svh
// timing and width constants for the delay pulse timer
`ifndef RDPT_CFG_SVH
`define RDPT_CFG_SVH

`define RDPT_CLK_MHZ        50
`define RDPT_MAX_STAGES     24
`define RDPT_STAGE_W        5
`define RDPT_CNT_W          26
`define RDPT_MIN_PULSE_NS   100
`define RDPT_MIN_PULSE_CYC  ((`RDPT_MIN_PULSE_NS * `RDPT_CLK_MHZ + 999) / 1000)
`define RDPT_MIN_CNT_W      4

`endif

// ===== rtl/rdpt_pkg.sv
// types shared by the delay pulse timer files
package rdpt_pkg;

  typedef enum logic [1:0] {
    RDPT_IDLE = 2'h1,
    RDPT_RUN  = 2'h2
  } rdpt_state_t;

endpackage : rdpt_pkg

// ===== rtl/rdpt_div_if.sv
// carrier between the timer control and its edge divider
`timescale 1ns/1ps
`default_nettype none
`include "rdpt_cfg.svh"

interface rdpt_div_if;
  logic                      clear;   // restart the count
  logic                      half_edge; // one clock edge of the time base seen
  logic [`RDPT_STAGE_W-1:0]  stages;  // effective stage count 1..24
  logic                      reached; // division count complete

  modport ctrl (output clear, output half_edge, output stages, input reached);
  modport div  (input clear, input half_edge, input stages, output reached);
endinterface : rdpt_div_if

`default_nettype wire

// ===== rtl/rdpt_divider.sv
// binary divider counting half periods of the time base
`timescale 1ns/1ps
`default_nettype none
`include "rdpt_cfg.svh"

module rdpt_divider (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_any,
  // control side
  rdpt_div_if.div   dv
);

  typedef struct packed {
    logic [`RDPT_CNT_W-1:0] cnt;
  } rdpt_div_st_t;

  rdpt_div_st_t st_q;
  rdpt_div_st_t st_d;

  // target is 2 to the power stages+1 half periods
  function automatic logic [`RDPT_CNT_W-1:0] half_target(
    input logic [`RDPT_STAGE_W-1:0] n);
    logic [`RDPT_CNT_W-1:0] one;
    one = `RDPT_CNT_W'(1);
    return one << (n + `RDPT_STAGE_W'(1));
  endfunction : half_target

  // next count, saturating at the target
  always_comb begin
    st_d = st_q;
    if (dv.clear) begin
      st_d.cnt = '0;
    end else if (dv.half_edge && st_q.cnt != half_target(dv.stages)) begin
      st_d.cnt = st_q.cnt + `RDPT_CNT_W'(1);
    end
  end

  // count register, cleared by reset or master clear
  always_ff @(posedge clk or posedge rst_any) begin
    if (rst_any) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // complete once the next half edge, rising or falling, would be the 2^(n+1)-th or later
  assign dv.reached = (st_q.cnt + `RDPT_CNT_W'(1)) >= half_target(dv.stages);

endmodule : rdpt_divider

`default_nettype wire

// ===== rtl/rdpt_timer.sv
// retriggerable delay pulse timer, top level
`timescale 1ns/1ps
`default_nettype none
`include "rdpt_cfg.svh"

// Notes on behaviour
// - a valid trigger raises the pulse on the next rising edge of clk, not at once.
// - trigger phase may lengthen or shorten the pulse by up to half a clock.
// - except on master clear or reset, the pulse always ends on a falling edge of the time base.
// - a retrigger extends the pulse only after a time-base edge has been seen.
// - too fast a time base loses falling-edge sync and undercounts.
// - up to 24 binary stages, nominal division two to the stage count.
// - the rising edge comes from the trigger, the falling from the clock.
// - the shortest output pulse is 100 ns.
module rdpt_timer (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // trigger side
  input  wire logic                     trig_pos,
  input  wire logic                     trig_n,
  input  wire logic                     master_clear,
  input  wire logic                     retrig_en,
  // time base side
  input  wire logic                     osc_clock_in,
  input  wire logic                     osc_keep_running,
  input  wire logic [`RDPT_STAGE_W-1:0] stage_sel,
  output var  logic                     osc_enable_q,
  // pulse outputs
  output var  logic                     pulse_q,
  output var  logic                     pulse_n_q
);

  typedef struct packed {
    rdpt_pkg::rdpt_state_t           state;
    logic                            osc_prev;
    logic                            trig_pos_prev;
    logic                            trig_n_prev;
    logic                            edge_seen;
    logic [`RDPT_MIN_CNT_W-1:0]      min_cnt;
    logic                            pulse;
    logic                            pulse_n;
    logic                            osc_en;
  } rdpt_st_t;

  rdpt_st_t    st_q;
  rdpt_st_t    st_d;
  logic        rst_any;
  logic        trig_evt;
  logic        osc_fall;
  logic        osc_edge;
  logic        min_done;
  rdpt_div_if  dv ();

  //////////////////////////////////////////////////////////////////////////
  // event detection

  // master clear joins the reset tree so it acts without the clock
  assign rst_any  = rst | master_clear;
  assign trig_evt = (trig_pos & ~st_q.trig_pos_prev)
                  | (~trig_n & st_q.trig_n_prev);
  assign osc_fall = st_q.osc_prev & ~osc_clock_in;
  assign osc_edge = st_q.osc_prev ^ osc_clock_in;
  assign min_done = st_q.min_cnt >= `RDPT_MIN_CNT_W'(`RDPT_MIN_PULSE_CYC - 1);

  //////////////////////////////////////////////////////////////////////////
  // divider

  // zero stages is taken as one, above the maximum as the maximum
  always_comb begin
    if (stage_sel == '0) begin
      dv.stages = `RDPT_STAGE_W'(1);
    end else if (stage_sel > `RDPT_STAGE_W'(`RDPT_MAX_STAGES)) begin
      dv.stages = `RDPT_STAGE_W'(`RDPT_MAX_STAGES);
    end else begin
      dv.stages = stage_sel;
    end
  end

  // half periods counted from the trigger set the phase error
  assign dv.half_edge = osc_edge & (st_q.state == rdpt_pkg::RDPT_RUN);
  assign dv.clear     = trig_evt & ((st_q.state == rdpt_pkg::RDPT_IDLE)
                      | (retrig_en & st_q.edge_seen));

  rdpt_divider u_div (
    .clk     (clk),
    .rst_any (rst_any),
    .dv      (dv)
  );

  //////////////////////////////////////////////////////////////////////////
  // pulse control

  // next state of the pulse machine
  always_comb begin
    st_d               = st_q;
    st_d.osc_prev      = osc_clock_in;
    st_d.trig_pos_prev = trig_pos;
    st_d.trig_n_prev   = trig_n;
    unique case (st_q.state)
      rdpt_pkg::RDPT_IDLE: begin
        if (trig_evt) begin
          st_d.state     = rdpt_pkg::RDPT_RUN;
          st_d.pulse     = 1'b1;
          st_d.pulse_n   = 1'b0;
          st_d.edge_seen = 1'b0;
          st_d.min_cnt   = '0;
        end
      end
      rdpt_pkg::RDPT_RUN: begin
        if (!min_done) begin
          st_d.min_cnt = st_q.min_cnt + `RDPT_MIN_CNT_W'(1);
        end
        if (osc_edge) begin
          st_d.edge_seen = 1'b1;
        end
        if (dv.clear) begin
          st_d.edge_seen = 1'b0;
        end else if (osc_fall && dv.reached && min_done) begin
          // edges of a time base faster than clk are missed, so sync is lost
          st_d.state   = rdpt_pkg::RDPT_IDLE;
          st_d.pulse   = 1'b0;
          st_d.pulse_n = 1'b1;
        end
      end
      default: begin
        st_d.state   = rdpt_pkg::RDPT_IDLE;
        st_d.pulse   = 1'b0;
        st_d.pulse_n = 1'b1;
      end
    endcase
    // the time base runs while timing or when held on by the host
    st_d.osc_en = osc_keep_running | (st_d.state == rdpt_pkg::RDPT_RUN);
  end

  // state register
  always_ff @(posedge clk or posedge rst_any) begin
    if (rst_any) begin
      st_q.state         <= rdpt_pkg::RDPT_IDLE;
      st_q.osc_prev      <= 1'b0;
      st_q.trig_pos_prev <= 1'b1; // no false start out of reset
      st_q.trig_n_prev   <= 1'b0;
      st_q.edge_seen     <= 1'b0;
      st_q.min_cnt       <= '0;
      st_q.pulse         <= 1'b0;
      st_q.pulse_n       <= 1'b1;
      st_q.osc_en        <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign pulse_q      = st_q.pulse;
  assign pulse_n_q    = st_q.pulse_n;
  assign osc_enable_q = st_q.osc_en;

endmodule : rdpt_timer

`default_nettype wire

// ===== tb/rdpt_chk.sv
// port assertions for the delay pulse timer
`timescale 1ns/1ps
`default_nettype none
module rdpt_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // triggers
  input wire logic trig_pos,
  input wire logic trig_n,
  input wire logic master_clear,
  // time base and outputs
  input wire logic osc_clock_in,
  input wire logic osc_keep_running,
  input wire logic osc_enable_q,
  input wire logic pulse_q,
  input wire logic pulse_n_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || master_clear);
  // trigger edges from idle raise the pulse, clear edges excluded
  AST_POS_GO: assert property ($rose(trig_pos) && !pulse_q
    && !$past(rst) && !$past(master_clear) |=> pulse_q)
    else $error("trig_pos did not raise pulse");
  AST_NEG_GO: assert property ($fell(trig_n) && !pulse_q
    && !$past(rst) && !$past(master_clear) |=> pulse_q)
    else $error("trig_n did not raise pulse");
  AST_COMPL: assert property (pulse_n_q == !pulse_q)
    else $error("outputs not complementary");
  // the pulse only drops one sample after a time base fall
  AST_END_FALL: assert property ($fell(pulse_q) |->
    $past(osc_clock_in, 2) && !$past(osc_clock_in))
    else $error("pulse ended off a falling edge");
  AST_HOLD: assert property (pulse_q && !($past(osc_clock_in)
    && !osc_clock_in) |=> pulse_q) else $error("pulse dropped early");
  AST_MIN: assert property ($rose(pulse_q) |-> pulse_q[*5])
    else $error("pulse shorter than 100 ns");
  AST_KEEP: assert property (osc_keep_running |=> osc_enable_q)
    else $error("time base not kept running");
  AST_RUN: assert property (pulse_q |-> osc_enable_q)
    else $error("time base stopped in a pulse");
  AST_CLR: assert property (disable iff (rst) master_clear |->
    !pulse_q && pulse_n_q) else $error("clear did not end pulse");
  // main scenarios
  cover property ($fell(pulse_q));
  cover property (pulse_q && $rose(trig_pos));
  cover property ($fell(trig_n));
endmodule : rdpt_chk
bind rdpt_timer rdpt_chk chk_u (.clk(clk), .rst(rst), .trig_pos(trig_pos),
  .trig_n(trig_n), .master_clear(master_clear), .osc_clock_in(osc_clock_in),
  .osc_keep_running(osc_keep_running), .osc_enable_q(osc_enable_q),
  .pulse_q(pulse_q), .pulse_n_q(pulse_n_q));
`default_nettype wire

// ===== tb/rdpt_osc_model.sv
// free running external time base
`timescale 1ns/1ps
`default_nettype none
module rdpt_osc_model (
  // clock and half period in cycles
  input  wire logic       clk,
  input  wire logic [7:0] half,
  // time base
  output var  logic       osc
);
  logic [7:0] cnt_q = 8'h00;
  initial osc = 1'b0;
  // never stops, so no start-up delay on triggers
  always @(posedge clk) begin
    cnt_q <= (cnt_q + 8'h01 >= half) ? 8'h00 : cnt_q + 8'h01;
    if (cnt_q + 8'h01 >= half) osc <= ~osc;
  end
endmodule : rdpt_osc_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the delay pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "rdpt_cfg.svh"
module testbench;
  logic clk = 1'b0, rst = 1'b1, trig_pos = 1'b0, trig_n = 1'b1;
  logic master_clear = 1'b0, retrig_en = 1'b0, keep = 1'b0;
  logic osc, osc_enable_q, pulse_q, pulse_n_q;
  logic [`RDPT_STAGE_W-1:0] stage_sel = 5'h01;
  logic [7:0] half = 8'h02;
  int mismatches = 0, checked = 0, cyc = 0, n;
  int exp_f[5] = '{2, 2, 4, 8, 16};
  initial forever #10 clk = ~clk;
  rdpt_osc_model osc_u (.clk(clk), .half(half), .osc(osc));
  rdpt_timer dut_u (.clk(clk), .rst(rst), .trig_pos(trig_pos),
    .trig_n(trig_n), .master_clear(master_clear), .retrig_en(retrig_en),
    .osc_clock_in(osc), .osc_keep_running(keep), .stage_sel(stage_sel),
    .osc_enable_q(osc_enable_q), .pulse_q(pulse_q), .pulse_n_q(pulse_n_q));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // trigger just after a time base fall
  task automatic fire(input logic neg);
    logic prev;
    do begin prev = osc; @(negedge clk); end while (!(prev && !osc));
    @(posedge clk);
    if (neg) trig_n <= 1'b0; else trig_pos <= 1'b1;
    @(posedge clk);
    {trig_n, trig_pos} <= 2'b10;
  endtask : fire
  // count time base falls until the pulse ends
  task automatic measure(output int f);
    logic prev;
    f = 0;
    prev = osc;
    repeat (3000) begin
      @(negedge clk);
      if (prev && !osc) f++;
      prev = osc;
      if (!pulse_q) break;
    end
  endtask : measure
  // retrigger gap cycles after the first trigger is taken
  task automatic retrig(input logic en, input int gap, input int exp);
    @(posedge clk);
    {retrig_en, stage_sel, half} <= {en, 5'h02, 8'h04};
    fire(1'b0);
    repeat (gap) @(posedge clk);
    trig_pos <= 1'b1;
    @(posedge clk);
    trig_pos <= 1'b0;
    measure(n);
    chk(n, exp);
    chk({pulse_q, pulse_n_q, osc_enable_q}, 3'h2);
  endtask : retrig
  // divisions and clear, both trigger inputs
  task automatic run_all;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      stage_sel <= i[4:0];
      fire(i[0]);
      measure(n);
      chk(n, exp_f[i]);
    end
    retrig(1'b1, 7, 4);
    retrig(1'b0, 7, 3);
    retrig(1'b1, 2, 4);
    fire(1'b0);
    repeat (2) @(posedge clk);
    master_clear <= 1'b1;
    @(negedge clk);
    chk({pulse_q, pulse_n_q}, 2'b01);
    fire(1'b0);
    @(negedge clk);
    chk(pulse_q, 1'b0);
    @(posedge clk);
    master_clear <= 1'b0;
    fire(1'b1);
    @(negedge clk);
    chk(pulse_q, 1'b1);
    measure(n);
    chk(n, 4);
  endtask : run_all
  // time limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end
  // reset, idle values, then the scenarios
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({pulse_q, pulse_n_q, osc_enable_q}, 3'b010);
    @(posedge clk);
    keep <= 1'b1;
    repeat (2) @(negedge clk);
    chk(osc_enable_q, 1'b1);
    @(posedge clk);
    keep <= 1'b0;
    run_all();
    test_done();
  end
endmodule : testbench
`default_nettype wire
